/* File: rtl/fsrq_pkg.sv */
package fsrq_pkg;

  // ********************************************************
  // Flash bus geometry
  // ********************************************************
  localparam int ADDR_W = 22;  // Word address width
  localparam int DATA_W = 16;  // Word data width

  // ********************************************************
  // Command words and addresses
  // ********************************************************
  localparam logic [21:0] UNLOCK_ADDR_A = 22'h00_0555;  // First unlock address
  localparam logic [21:0] UNLOCK_ADDR_B = 22'h00_02AA;  // Second unlock address
  localparam logic [15:0] UNLOCK_DATA_A = 16'h00AA;  // First unlock data
  localparam logic [15:0] UNLOCK_DATA_B = 16'h0055;  // Second unlock data
  localparam logic [15:0] REGION_ENTER_DATA = 16'h0088;  // Secured region entry
  localparam logic [15:0] REGION_EXIT_DATA = 16'h0090;  // Secured region exit, cycle 3
  localparam logic [15:0] REGION_EXIT_ZERO = 16'h0000;  // Secured region exit, cycle 4
  localparam logic [15:0] PROGRAM_DATA = 16'h00A0;  // Program setup
  localparam logic [21:0] QUERY_ADDR = 22'h00_0055;  // Query entry address, word mode
  localparam logic [15:0] QUERY_DATA = 16'h0098;  // Query entry data
  localparam logic [15:0] RESET_DATA = 16'h00F0;  // Reset to array read

  // ********************************************************
  // Query table addresses and fixed values
  // ********************************************************
  localparam logic [21:0] QRY_FIRST = 22'h00_0010;  // First identification word
  localparam int QRY_LEN = 45;  // Words 10h through 3Ch
  localparam logic [7:0] QRY_Q = 8'h51;  // Identification letter one
  localparam logic [7:0] QRY_R = 8'h52;  // Identification letter two
  localparam logic [7:0] QRY_Y = 8'h59;  // Identification letter three
  localparam logic [7:0] SECURED_LAST = 8'h0F;  // Last random plus serial word

  // ********************************************************
  // Strobe timing
  // ********************************************************
  localparam int STROBE_NS = 70;  // Least strobe and access time
  localparam int CLK_NS = 8;  // System clock period
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;  // Rounded up

  // ********************************************************
  // Request and answer carriers
  // ********************************************************
  typedef enum logic [2:0] {
    FSRQ_OP_READ = 3'd0,  // Plain array read
    FSRQ_OP_QUERY = 3'd1,  // Read whole query table and check it
    FSRQ_OP_REGION_RD = 3'd2,  // Read secured region words 0..15
    FSRQ_OP_REGION_PG = 3'd3,  // Program one secured region word
    FSRQ_OP_RESET = 3'd4  // Write reset command
  } fsrq_op_e;

  typedef struct packed {
    fsrq_op_e op;  // Operation
    logic [21:0] addr;  // Word address
    logic [15:0] data;  // Write data
  } fsrq_req_s;

  typedef struct packed {
    logic [15:0] data;  // Last read word
    logic query_ok;  // Query table matched
    logic factory_locked;  // Lock indicator seen
    logic refused;  // Request refused
  } fsrq_rsp_s;

  typedef struct packed {
    logic ce_n;  // Chip select
    logic we_n;  // Write strobe
    logic oe_n;  // Output enable
    logic [21:0] addr;  // Address
    logic [15:0] dq_out;  // Data out
    logic dq_oe;  // Data drive enable
  } fsrq_pins_s;

endpackage : fsrq_pkg

/* File: rtl/fsrq_host.sv */
`timescale 1ns/100ps
`default_nettype none
module fsrq_host
  import fsrq_pkg::*;
(
  input wire logic clk_sys,  // System clock, 125 MHz
  input wire logic rst_n,  // Asynchronous reset, active low
  input wire logic req_valid,  // Request present
  output logic req_ready,  // Request taken this cycle
  input wire fsrq_req_s req,  // Request contents
  input wire logic supply_ok,  // Supply above lockout threshold
  input wire logic lock_indicator_bit,  // Lock indicator from identification read
  output logic rsp_valid,  // Answer pulse
  output fsrq_rsp_s rsp,  // Answer, registered
  output fsrq_pins_s pins,  // Flash strobes and bus, registered
  input wire logic [15:0] dq_in  // Flash data in
);

  // ********************************************************
  // Query table expected from the device
  // ********************************************************
  // Table value for query word 10h + i
  function automatic logic [7:0] qry_val(input logic [5:0] i);
    case (i)
      6'd0: qry_val = QRY_Q;
      6'd1: qry_val = QRY_R;
      6'd2: qry_val = QRY_Y;
      6'd3: qry_val = 8'h02;
      6'd5: qry_val = 8'h40;
      6'd11: qry_val = 8'h27;
      6'd12: qry_val = 8'h36;
      6'd15: qry_val = 8'h04;
      6'd17: qry_val = 8'h0A;
      6'd19: qry_val = 8'h05;
      6'd21: qry_val = 8'h04;
      6'd23: qry_val = 8'h17;
      6'd24: qry_val = 8'h02;
      6'd28: qry_val = 8'h03;
      6'd29, 6'd37: qry_val = 8'h07;
      6'd31, 6'd39: qry_val = 8'h20;
      6'd33: qry_val = 8'h7D;
      6'd36: qry_val = 8'h01;
      default: qry_val = 8'h00;  // Reserved, alternate and region four words read zero
    endcase
  endfunction : qry_val

  // ********************************************************
  // Sequencer state
  // ********************************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,  // Waiting for a request
    S_WR = 5'b00010,  // Write strobe low
    S_WGAP = 5'b00100,  // Strobes high between cycles
    S_RD = 5'b01000,  // Output enable low, sampling
    S_DONE = 5'b10000  // Answer pulse
  } fsrq_st_e;

  fsrq_st_e st, next_st;  // Current and next state
  logic [7:0] cnt, next_cnt;  // Strobe timer
  logic [3:0] step, next_step;  // Write cycle index within sequence
  logic [3:0] nsteps, next_nsteps;  // Write cycles before the read or the end
  logic [5:0] idx, next_idx;  // Read index in multi-word reads
  logic do_read, next_do_read;  // A read follows the writes
  fsrq_req_s cur, next_cur;  // Latched request
  fsrq_pins_s next_pins;  // Next pin values
  fsrq_rsp_s next_rsp;  // Next answer
  logic next_rsp_valid;  // Next answer pulse
  logic in_query, next_in_query;  // Host believes the device is in query mode

  // Command write cycle for step s of the current operation
  function automatic logic [37:0] seq_cycle(input fsrq_op_e op, input logic [3:0] s,
                                            input logic [21:0] a, input logic [15:0] d);
    logic [37:0] r;
    r = {a, d};
    case (op)
      FSRQ_OP_QUERY: r = {QUERY_ADDR, QUERY_DATA};
      FSRQ_OP_RESET: r = {UNLOCK_ADDR_A, RESET_DATA};
      default: begin
        // Region access: enter, optional program, then exit
        case (s)
          4'd0, 4'd3, 4'd7: r = {UNLOCK_ADDR_A, UNLOCK_DATA_A};
          4'd1, 4'd4, 4'd8: r = {UNLOCK_ADDR_B, UNLOCK_DATA_B};
          4'd2: r = {UNLOCK_ADDR_A, REGION_ENTER_DATA};
          // Reads exit on steps 3 to 6; programs put setup and data there first
          4'd5: r = (op == FSRQ_OP_REGION_PG) ? {UNLOCK_ADDR_A, PROGRAM_DATA} : {UNLOCK_ADDR_A, REGION_EXIT_DATA};
          4'd6: r = (op == FSRQ_OP_REGION_PG) ? {a, d} : {UNLOCK_ADDR_A, REGION_EXIT_ZERO};
          4'd9: r = {UNLOCK_ADDR_A, REGION_EXIT_DATA};
          default: r = {UNLOCK_ADDR_A, REGION_EXIT_ZERO};
        endcase
      end
    endcase
    seq_cycle = r;
  endfunction : seq_cycle

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_step = step;
    next_nsteps = nsteps;
    next_idx = idx;
    next_do_read = do_read;
    next_cur = cur;
    next_pins = pins;
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    next_in_query = in_query;
    req_ready = 1'b0;
    case (st)
      S_IDLE: begin
        next_pins.ce_n = 1'b1;
        next_pins.we_n = 1'b1;
        next_pins.oe_n = 1'b1;
        next_pins.dq_oe = 1'b0;
        // Hold off while supply is low, writes would be lost
        if (req_valid && supply_ok) begin
          req_ready = 1'b1;
          next_cur = req;
          next_step = 4'd0;
          next_idx = 6'd0;
          next_cnt = 8'd0;
          next_rsp.refused = 1'b0;
          case (req.op)
            FSRQ_OP_READ: begin
              next_nsteps = 4'd0;
              next_do_read = 1'b1;
            end
            FSRQ_OP_QUERY: begin
              // Only taken from idle, once the previous sequence is over
              next_nsteps = 4'd1;
              next_do_read = 1'b1;
              next_in_query = 1'b1;
            end
            FSRQ_OP_RESET: begin
              next_nsteps = 4'd1;
              next_do_read = 1'b0;
              next_in_query = 1'b0;
            end
            FSRQ_OP_REGION_PG: begin
              // Never program a factory-locked region
              // Enter, setup, data, then the four exit cycles
              next_nsteps = 4'd11;
              next_do_read = 1'b0;
            end
            default: begin
              next_nsteps = 4'd3;
              next_do_read = 1'b1;
            end
          endcase
          if (req.op == FSRQ_OP_REGION_PG && lock_indicator_bit) begin
            next_rsp.refused = 1'b1;
            next_st = S_DONE;
          end else if (req.op == FSRQ_OP_READ) begin
            next_st = S_RD;
            next_pins.addr = req.addr;
            next_pins.ce_n = 1'b0;
            next_pins.oe_n = 1'b0;
          end else begin
            next_st = S_WR;
            {next_pins.addr, next_pins.dq_out} = seq_cycle(req.op, 4'd0, req.addr, req.data);
            next_pins.ce_n = 1'b0;
            next_pins.we_n = 1'b0;  // Output enable stays high
            next_pins.dq_oe = 1'b1;
          end
        end
      end
      S_WR: begin
        next_cnt = cnt + 8'd1;
        if (cnt == 8'(STROBE_CYC - 1)) begin
          next_cnt = 8'd0;
          next_pins.we_n = 1'b1;  // Rising edge latches the data
          next_pins.ce_n = 1'b1;
          next_st = S_WGAP;
        end
      end
      S_WGAP: begin
        next_cnt = cnt + 8'd1;
        if (cnt == 8'(STROBE_CYC - 1)) begin
          next_cnt = 8'd0;
          next_pins.dq_oe = 1'b0;
          if (step + 4'd1 < nsteps) begin
            next_step = step + 4'd1;
            {next_pins.addr, next_pins.dq_out} = seq_cycle(cur.op, step + 4'd1, cur.addr, cur.data);
            next_pins.ce_n = 1'b0;
            next_pins.we_n = 1'b0;
            next_pins.dq_oe = 1'b1;
            next_st = S_WR;
          end else if (do_read) begin
            next_st = S_RD;
            next_pins.ce_n = 1'b0;
            next_pins.oe_n = 1'b0;
            // Query reads start at 10h, region reads at boot word 0
            next_pins.addr = (cur.op == FSRQ_OP_QUERY) ? QRY_FIRST :
                             (cur.op == FSRQ_OP_READ) ? cur.addr : 22'h00_0000;
          end else begin
            next_st = S_DONE;
          end
        end
      end
      S_RD: begin
        next_cnt = cnt + 8'd1;
        if (cnt == 8'(STROBE_CYC - 1)) begin
          next_cnt = 8'd0;
          next_rsp.data = dq_in;
          if (cur.op == FSRQ_OP_QUERY) begin
            // Upper byte must be zero in word mode
            if (idx == 6'd0)
              next_rsp.query_ok = (dq_in == {8'h00, qry_val(idx)});
            else
              next_rsp.query_ok = rsp.query_ok && (dq_in == {8'h00, qry_val(idx)});
          end
          if (cur.op == FSRQ_OP_QUERY && idx < 6'(QRY_LEN - 1) ||
              cur.op == FSRQ_OP_REGION_RD && idx < 6'(SECURED_LAST)) begin
            next_idx = idx + 6'd1;
            next_pins.addr = pins.addr + 22'h00_0001;
          end else begin
            next_pins.oe_n = 1'b1;
            next_pins.ce_n = 1'b1;
            if (cur.op == FSRQ_OP_REGION_RD) begin
              // Leave the region with the exit sequence
              next_step = 4'd2;
              next_nsteps = 4'd7;
              next_do_read = 1'b0;
              next_st = S_WGAP;
            end else begin
              next_st = S_DONE;
            end
          end
        end
      end
      S_DONE: begin
        next_rsp_valid = 1'b1;
        next_rsp.factory_locked = lock_indicator_bit;
        next_st = S_IDLE;
      end
      default: next_st = S_IDLE;
    endcase
  end

  // Region reads exit on steps 3 to 6, region programs on steps 7 to 10
  // ********************************************************
  // State registers
  // ********************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      cnt <= 8'd0;
      step <= 4'd0;
      nsteps <= 4'd0;
      idx <= 6'd0;
      do_read <= 1'b0;
      cur <= '0;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 22'h00_0000, dq_out: 16'h0000, dq_oe: 1'b0};
      rsp <= '0;
      rsp_valid <= 1'b0;
      in_query <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      step <= next_step;
      nsteps <= next_nsteps;
      idx <= next_idx;
      do_read <= next_do_read;
      cur <= next_cur;
      pins <= next_pins;
      rsp <= next_rsp;
      rsp_valid <= next_rsp_valid;
      in_query <= next_in_query;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  a_write_strobe_legal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pins.we_n |-> (!pins.ce_n && pins.oe_n)) else $error("write without select or with enable low");
  a_no_locked_program: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st == S_IDLE && req_valid && req.op == FSRQ_OP_REGION_PG && lock_indicator_bit && supply_ok)
    |=> (st == S_DONE && rsp.refused)) else $error("program to locked region not refused");
  a_low_supply_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st == S_IDLE && !supply_ok) |-> !req_ready) else $error("request taken below lockout");
  a_query_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st == S_IDLE && req_ready && req.op == FSRQ_OP_QUERY)
    |=> (pins.addr == QUERY_ADDR && pins.dq_out == QUERY_DATA && !pins.we_n)) else $error("bad query entry");
  a_reset_cmd: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st == S_IDLE && req_ready && req.op == FSRQ_OP_RESET)
    |=> pins.dq_out == RESET_DATA ##1 !in_query) else $error("bad reset command");
  a_strobe_width: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(pins.we_n) |-> !pins.we_n [*8]) else $error("write strobe too short");
  a_query_first_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st == S_WGAP && next_st == S_RD && cur.op == FSRQ_OP_QUERY)
    |=> (pins.addr == QRY_FIRST && !pins.oe_n && pins.we_n)) else $error("query read not started at first word");
  a_region_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st == S_RD && cur.op == FSRQ_OP_REGION_RD && next_st == S_WGAP)
    |=> ##[1:200] (!pins.we_n && pins.dq_out == REGION_EXIT_DATA)) else $error("region not exited");

endmodule : fsrq_host
`default_nettype wire

/* File: verif/fsrq_flash_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Behavioural flash device on the far side
// ****************************************
module fsrq_flash_model
  import fsrq_pkg::*;
#(
  parameter logic [15:0] RND_BASE = 16'h3C00  // Arbitrary locked content base
) (
  input wire fsrq_pins_s pins,  // Host strobes and bus
  input wire logic supply_ok,  // Supply above lockout threshold
  input wire logic locked,  // Factory-locked part
  input wire logic [1:0] fault,  // 1 bad query bit, 2 upper byte set
  output logic lock_bit,  // Lock indicator readout
  output logic [15:0] dq_in  // Data towards the host
);
  // Query words 10h to 3Ch, low byte; upper byte zero except bit 8 of word 10h under fault 2
  localparam logic [7:0] QTAB [45] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h27, 8'h36, 8'h00, 8'h00, 8'h04, 8'h00, 8'h0A, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'h17, 8'h02,
    8'h00, 8'h00, 8'h00, 8'h03, 8'h07, 8'h00, 8'h20, 8'h00, 8'h7D, 8'h00, 8'h00, 8'h01, 8'h07, 8'h00, 8'h20,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic qry = 1'b0;  // Query mode; power-up is array read
  logic in_reg = 1'b0;  // Secured region mapped at boot addresses
  logic pgm = 1'b0;  // Next write is program data
  logic exitp = 1'b0;  // Next write finishes region exit
  int step = 0;  // Unlock cycles seen
  int idx;  // Query table index
  logic [15:0] mem [16];  // Customer region words, erased
  logic [15:0] rd;  // Word the device would present
  logic [15:0] last_q = 16'h0000;  // Last driven word
  wire sel = !pins.ce_n && !pins.oe_n;  // Read strobe active
  // A write cycle ends on whichever of select and strobe rises first
  wire wr_act = !pins.ce_n && !pins.we_n && pins.oe_n;  // Write cycle in progress
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
  end
  assign lock_bit = locked;
  // Read path
  always @* begin
    idx = int'(pins.addr) - 16;
    rd = {pins.addr[7:0], ~pins.addr[7:0]};
    if (qry) begin
      rd = 16'h0000;
      if (idx >= 0 && idx < 45) rd = {8'h00, QTAB[idx]};
      if (fault == 2'd1 && idx == 11) rd[0] = ~rd[0];
      if (fault == 2'd2 && idx == 0) rd[8] = 1'b1;
    end else if (in_reg && pins.addr < 22'h00_0080) begin
      rd = 16'hFFFF;
      if (pins.addr < 22'h00_0010) rd = locked ? RND_BASE + 16'(pins.addr[3:0]) : mem[pins.addr[3:0]];
    end
  end
  always @* begin
    if (sel) last_q = rd;
  end
  // A released bus never shows the stale word, so a late sample is caught
  assign dq_in = sel ? rd : ~last_q;
  // Low supply drops query and program modes back to array read; the secured region mapping stays
  always @(negedge supply_ok) begin
    qry = 1'b0;
    step = 0;
    pgm = 1'b0;
  end
  // Commands are taken as each write cycle ends; select and strobe may rise together
  always @(negedge wr_act) begin
    if (supply_ok) begin
      if (pgm) begin
        if (in_reg && !locked && pins.addr < 22'h00_0010) mem[pins.addr[3:0]] &= pins.dq_out;
        pgm = 1'b0;
      end else if (exitp) begin
        if (pins.dq_out == REGION_EXIT_ZERO) in_reg = 1'b0;
        exitp = 1'b0;
      end else if (pins.dq_out == RESET_DATA) begin
        qry = 1'b0;
        step = 0;
      end else if (pins.addr == QUERY_ADDR && pins.dq_out == QUERY_DATA) qry = 1'b1;
      else if (pins.addr == UNLOCK_ADDR_A && pins.dq_out == UNLOCK_DATA_A) step = 1;
      else if (step == 1 && pins.addr == UNLOCK_ADDR_B && pins.dq_out == UNLOCK_DATA_B) step = 2;
      else if (step == 2) begin
        step = 0;
        if (pins.dq_out == REGION_ENTER_DATA) in_reg = 1'b1;
        if (pins.dq_out == REGION_EXIT_DATA) exitp = 1'b1;
        if (pins.dq_out == PROGRAM_DATA) pgm = 1'b1;
      end else step = 0;
    end
  end
endmodule : fsrq_flash_model
`default_nettype wire

/* File: verif/test_fsrq_host.sv */
`timescale 1ns/100ps
`default_nettype none
module test_fsrq_host
  import fsrq_pkg::*;
;
  localparam logic [15:0] RND_BASE = 16'h3C00;  // Arbitrary locked content base
  typedef struct packed {fsrq_rsp_s v; logic [3:0] m;} fsrq_exp_s;  // Expected answer and field mask
  logic clk_sys = 1'b0;  // 125 MHz clock
  logic rst_n, req_valid, req_ready, supply_ok, lock_bit, rsp_valid, locked;  // Bench wires
  logic [1:0] fault;  // Model fault selector
  logic [15:0] dq_in, v;  // Flash data, random word
  logic [21:0] a;  // Random address
  fsrq_req_s req;  // Request
  fsrq_rsp_s rsp;  // Answer
  fsrq_pins_s pins;  // Flash pins
  fsrq_exp_s q[$];  // Pending expectations
  fsrq_exp_s e;  // Expectation being compared
  int failures = 0, total_checks = 0, seed = 24, ce_falls = 0, n;  // Counters
  always #4 clk_sys = ~clk_sys;
  always @(negedge pins.ce_n) ce_falls++;
  fsrq_host u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .supply_ok(supply_ok), .lock_indicator_bit(lock_bit), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .dq_in(dq_in));
  fsrq_flash_model #(.RND_BASE(RND_BASE)) u_flash (.pins(pins), .supply_ok(supply_ok), .locked(locked),
    .fault(fault), .lock_bit(lock_bit), .dq_in(dq_in));
  // ****************************************
  // Compare, finish and helpers
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  function automatic fsrq_rsp_s mk(input logic [15:0] d, input logic qok, input logic fl, input logic rf);
    return '{data: d, query_ok: qok, factory_locked: fl, refused: rf};
  endfunction : mk
  function automatic logic [15:0] arr(input logic [21:0] x);
    return {x[7:0], ~x[7:0]};  // Model array contents
  endfunction : arr
  // One request, held until taken, then wait for its answer
  task automatic do_req(input fsrq_op_e op, input logic [21:0] ad, input logic [15:0] d, input fsrq_rsp_s ev,
                        input logic [3:0] m);
    int k;
    req = '{op: op, addr: ad, data: d};
    req_valid = 1'b1;
    k = 0;
    @(negedge clk_sys);
    while (req_ready !== 1'b1 && k < 4000) begin
      @(negedge clk_sys);
      k++;
    end
    q.push_back('{v: ev, m: m});
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    k = 0;
    while (q.size() > 0 && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    check("answer arrived", 16'(q.size()), 16'h0000);
    #1;
  endtask : do_req
  // Answer watcher: takes the oldest note per answer pulse
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      if (e.m[3]) check("rsp data", rsp.data, e.v.data);
      if (e.m[2]) check("query ok", 16'(rsp.query_ok), 16'(e.v.query_ok));
      if (e.m[1]) check("factory locked", 16'(rsp.factory_locked), 16'(e.v.factory_locked));
      if (e.m[0]) check("refused", 16'(rsp.refused), 16'(e.v.refused));
    end else if (rsp_valid === 1'b1) check("unexpected answer", 16'h0001, 16'h0000);
  end
  // Hang guard, reckoned well above the expected run of some 2500 cycles
  initial begin
    #400000;
    failures++;
    $display("watchdog expired");
    report_and_stop();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    supply_ok = 1'b1;
    locked = 1'b0;
    fault = 2'd0;
    repeat (2) @(posedge clk_sys);
    #1 check("ce_n in reset", 16'(pins.ce_n), 16'h0001);
    check("dq_oe in reset", 16'(pins.dq_oe), 16'h0000);
    check("rsp_valid in reset", 16'(rsp_valid), 16'h0000);
    rst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    for (int i = 0; i < 4; i++) begin
      a = 22'($random(seed));
      do_req(FSRQ_OP_READ, a, 16'($random(seed)), mk(arr(a), 0, 0, 0), 4'b1000);
    end
    $display("test array read done");
    // Good table, a wrong bit, then a nonzero upper byte
    for (int f = 0; f < 3; f++) begin
      fault = 2'(f);
      do_req(FSRQ_OP_QUERY, 22'h00_0000, 16'h0000, mk(16'h0000, f == 0, 0, 0), 4'b0100);
      do_req(FSRQ_OP_RESET, 22'h00_0000, 16'h0000, mk(16'h0000, 0, 0, 0), 4'b0000);
      do_req(FSRQ_OP_READ, 22'h00_0011, 16'h0000, mk(arr(22'h00_0011), 0, 0, 0), 4'b1000);
    end
    fault = 2'd0;
    $display("test query done");
    locked = 1'b1;
    do_req(FSRQ_OP_REGION_RD, 22'h00_0000, 16'h0000, mk(RND_BASE + 16'h000F, 0, 1, 0), 4'b1010);
    n = ce_falls;
    do_req(FSRQ_OP_REGION_PG, 22'h00_000F, 16'h0000, mk(16'h0000, 0, 0, 1), 4'b0001);
    check("strobes on refusal", 16'(ce_falls - n), 16'h0000);
    do_req(FSRQ_OP_REGION_RD, 22'h00_0000, 16'h0000, mk(RND_BASE + 16'h000F, 0, 1, 0), 4'b1010);
    do_req(FSRQ_OP_READ, 22'h00_0005, 16'h0000, mk(arr(22'h00_0005), 0, 0, 0), 4'b1000);
    $display("test factory locked done");
    locked = 1'b0;
    v = 16'($random(seed));
    do_req(FSRQ_OP_REGION_PG, 22'h00_000F, v, mk(16'h0000, 0, 0, 0), 4'b0001);
    do_req(FSRQ_OP_REGION_RD, 22'h00_0000, 16'h0000, mk(v, 0, 0, 0), 4'b1010);
    do_req(FSRQ_OP_READ, 22'h00_000F, 16'h0000, mk(arr(22'h00_000F), 0, 0, 0), 4'b1000);
    $display("test customer region done");
    // Low supply stalls the request and keeps the strobes still
    supply_ok = 1'b0;
    n = ce_falls;
    fork
      do_req(FSRQ_OP_READ, 22'h00_0123, 16'h0000, mk(arr(22'h00_0123), 0, 0, 0), 4'b1000);
      begin
        repeat (20) begin
          @(negedge clk_sys);
          check("ready in lockout", 16'(req_ready), 16'h0000);
        end
        check("strobes in lockout", 16'(ce_falls - n), 16'h0000);
        @(posedge clk_sys);
        #1 supply_ok = 1'b1;
      end
    join
    $display("test lockout done");
    report_and_stop();
  end
endmodule : test_fsrq_host
`default_nettype wire
